// >>> logic/scdec_decode.sv
/*
  Host I/O address decoder and interrupt router for a two-channel serial
  adapter. Holds the block compare, port selects, read mux and IRQ steering.
  Assumes host strobes are synchronous to clk and one cycle wide; the
  controller and board port answer reads combinationally in that cycle.
*/
`timescale 1ns/1ps
// Overview of operation
// - Respond only to eight consecutive addresses starting at the base
// - Base may sit anywhere from 100 to 3F8 hex, eight-aligned
// - Closed switch demands address bit zero, open switch demands one
// - Seven switches map to A9..A3; low three bits ignored in compare
// - Offset 0 is channel A data, offset 1 channel A control
// - Offset 2 is channel B data, offset 3 channel B control
// - Offset 4 is the board control and status port
// - Factory setting is base 238 hex and interrupt line 5
// - Controller interrupt goes to one of 2/9,3,4,5, or to none
// - Normal mode drives the chosen line exclusively
// - Shared mode lets ports share a line; one port pulls it down
module scdec_decode
  import scdec_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] host_addr,
  input  wire logic [DATA_W-1:0] host_wdata,
  input  wire logic              host_rd,
  input  wire logic              host_wr,
  input  wire logic              host_aen,
  output logic      [DATA_W-1:0] host_rdata,
  output logic                   host_hit,
  input  wire logic [SW_W-1:0]   base_address_switch,
  input  wire logic [IRQ_N-1:0]  interrupt_select_header,
  input  wire logic              shared_mode,
  input  wire logic              pulldown_fitted,
  output logic      [4:0]        port_rd,
  output logic      [4:0]        port_wr,
  output logic      [DATA_W-1:0] port_wdata,
  input  wire logic [DATA_W-1:0] serial_rdata,
  input  wire logic [DATA_W-1:0] board_rdata,
  input  wire logic              dual_serial_controller_irq,
  output logic      [IRQ_N-1:0]  irq_out,
  output logic      [IRQ_N-1:0]  irq_oe_n,
  output logic      [IRQ_N-1:0]  irq_pulldown
);

  typedef struct packed {
    logic [SW_W-1:0]   sw;
    logic [IRQ_N-1:0]  irqsel;
    logic [DATA_W-1:0] rdata;
    logic              hit;
    logic [4:0]        rd;
    logic [4:0]        wr;
    logic [DATA_W-1:0] wdata;
    logic [IRQ_N-1:0]  irq;
    logic [IRQ_N-1:0]  oe_n;
    logic [IRQ_N-1:0]  pd;
  } scdec_state_t;

  scdec_state_t st_ff;
  scdec_state_t nxt_st;

  logic        in_block;
  logic [2:0]  ofs;
  scdec_sel_t  sel;
  logic        sel_valid;
  logic [IRQ_N-1:0] irq_onehot;
  logic [9:0]  base;

  // Base from switches; closed switch reads as 0 on its address bit
  assign base = {st_ff.sw, 3'h0};
  // Only the upper seven bits are compared, offset bits are free
  assign in_block = host_aen && (host_addr[9:3] == st_ff.sw);
  assign ofs = host_addr[2:0];
  // A header with more than one jumper is treated as no selection
  assign irq_onehot = ($onehot(st_ff.irqsel)) ? st_ff.irqsel : '0;

  // Offset to port select
  always_comb begin
    case (ofs)
      OFS_CHAN_A_DATA: sel = SCDEC_SEL_AD;
      OFS_CHAN_A_CTRL: sel = SCDEC_SEL_AC;
      OFS_CHAN_B_DATA: sel = SCDEC_SEL_BD;
      OFS_CHAN_B_CTRL: sel = SCDEC_SEL_BC;
      OFS_BOARD_CS:    sel = SCDEC_SEL_CS;
      default:         sel = SCDEC_SEL_NONE;
    endcase
  end
  // Bases below 100 hex sit on motherboard ports and never decode
  assign sel_valid = in_block && (base >= BASE_MIN)
                     && (base <= BASE_MAX);

  // Next state: straps sampled every cycle, strobes and data registered
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.sw     = base_address_switch;
    nxt_st.irqsel = interrupt_select_header;
    nxt_st.hit    = sel_valid && (host_rd || host_wr);
    nxt_st.rd     = (sel_valid && host_rd) ? sel : '0;
    nxt_st.wr     = (sel_valid && host_wr) ? sel : '0;
    nxt_st.wdata  = host_wdata;
    if (sel_valid && host_rd && (sel == SCDEC_SEL_CS)) begin
      nxt_st.rdata = board_rdata;
    end else if (sel_valid && host_rd && (sel != SCDEC_SEL_NONE)) begin
      nxt_st.rdata = serial_rdata;
    end else begin
      nxt_st.rdata = UNDEF_READ;
    end
    // Normal mode drives the line both ways; shared only pulls it high
    nxt_st.irq  = dual_serial_controller_irq ? irq_onehot : '0;
    if (shared_mode) begin
      nxt_st.oe_n = ~(irq_onehot & {IRQ_N{dual_serial_controller_irq}});
      nxt_st.pd   = pulldown_fitted ? irq_onehot : '0;
    end else begin
      nxt_st.oe_n = ~irq_onehot;
      nxt_st.pd   = '0;
    end
  end

  // State register; reset loads factory straps until first sample
  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff.sw     <= DEFAULT_SWITCH;
      st_ff.irqsel <= DEFAULT_IRQ_SEL;
      st_ff.rdata  <= UNDEF_READ;
      st_ff.hit    <= 1'b0;
      st_ff.rd     <= '0;
      st_ff.wr     <= '0;
      st_ff.wdata  <= '0;
      st_ff.irq    <= '0;
      st_ff.oe_n   <= '1;
      st_ff.pd     <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign host_rdata   = st_ff.rdata;
  assign host_hit     = st_ff.hit;
  assign port_rd      = st_ff.rd;
  assign port_wr      = st_ff.wr;
  assign port_wdata   = st_ff.wdata;
  assign irq_out      = st_ff.irq;
  assign irq_oe_n     = st_ff.oe_n;
  assign irq_pulldown = st_ff.pd;

  // Host cycle shapes; every strobe is judged one cycle after its request
  sequence s_host_cyc;
    host_aen && (host_rd || host_wr);
  endsequence

  sequence s_rd_cyc;
    host_aen && host_rd;
  endsequence

  sequence s_wr_cyc;
    host_aen && host_wr;
  endsequence

  a_block_only: assert property (@(posedge clk) disable iff (srst)
      (s_host_cyc and (host_addr[9:3] != st_ff.sw)) |=> !host_hit)
    else $error("hit outside decoded block");
  // DMA cycles carry addresses too, so they must never reach a port
  a_dma_ignored: assert property (@(posedge clk) disable iff (srst)
      !host_aen |=> !host_hit && port_rd == 5'h00 && port_wr == 5'h00)
    else $error("DMA cycle decoded as host access");
  a_chan_a_ctrl: assert property (@(posedge clk) disable iff (srst)
      (s_rd_cyc and (sel_valid && host_addr[2:0] == 3'h1))
      |=> port_rd == 5'h02 && host_rdata == $past(serial_rdata))
    else $error("offset 1 read missed channel A control");
  a_chan_b_data: assert property (@(posedge clk) disable iff (srst)
      (s_wr_cyc and (sel_valid && host_addr[2:0] == 3'h2))
      |=> port_wr == 5'h04 && port_wdata == $past(host_wdata))
    else $error("offset 2 write missed channel B data");
  a_board_write: assert property (@(posedge clk) disable iff (srst)
      (s_wr_cyc and (sel_valid && host_addr[2:0] == 3'h4))
      |=> port_wr == 5'h10)
    else $error("offset 4 write missed board port");
  a_undef_read: assert property (@(posedge clk) disable iff (srst)
      !(sel_valid && host_rd) |=> host_rdata == UNDEF_READ)
    else $error("read data not idle value without decoded read");
  a_chan_a_data: assert property (@(posedge clk) disable iff (srst)
      sel_valid && host_wr && host_addr[2:0] == 3'h0
      |=> port_wr == 5'h01)
    else $error("offset 0 write missed channel A data");
  a_chan_b_ctrl: assert property (@(posedge clk) disable iff (srst)
      sel_valid && host_rd && host_addr[2:0] == 3'h3
      |=> port_rd == 5'h08)
    else $error("offset 3 read missed channel B control");
  a_board_port: assert property (@(posedge clk) disable iff (srst)
      sel_valid && host_rd && host_addr[2:0] == 3'h4
      |=> port_rd == 5'h10 && host_rdata == $past(board_rdata))
    else $error("offset 4 read missed board port");
  a_high_ofs: assert property (@(posedge clk) disable iff (srst)
      (s_host_cyc and (host_addr[2:0] > 3'h4)) |=> port_wr == 5'h00
      && port_rd == 5'h00)
    else $error("offset 5-7 selected a port");
  a_low_base: assert property (@(posedge clk) disable iff (srst)
      (s_host_cyc and (st_ff.sw < 7'h20)) |=> !host_hit)
    else $error("base below 100 hex decoded");
  a_switch_map: assert property (@(posedge clk) disable iff (srst)
      (s_host_cyc and (host_addr[9:3] == st_ff.sw && st_ff.sw >= 7'h20))
      |=> host_hit)
    else $error("matching switch address not decoded");
  a_irq_route: assert property (@(posedge clk) disable iff (srst)
      !shared_mode && $onehot(st_ff.irqsel)
      |=> irq_oe_n == ~$past(st_ff.irqsel))
    else $error("normal mode not driving selected line");
  a_irq_none: assert property (@(posedge clk) disable iff (srst)
      st_ff.irqsel == 4'h0 |=> irq_oe_n == 4'hF && irq_out == 4'h0)
    else $error("interrupt driven with no line selected");
  a_irq_level: assert property (@(posedge clk) disable iff (srst)
      dual_serial_controller_irq |=> irq_out == $past(irq_onehot))
    else $error("active interrupt not on selected line");
  // A shared line must be let go so the other ports can pull it
  a_shared_release: assert property (@(posedge clk) disable iff (srst)
      shared_mode && !dual_serial_controller_irq |=> irq_oe_n == 4'hF)
    else $error("shared line driven while interrupt idle");
  a_shared_pd: assert property (@(posedge clk) disable iff (srst)
      shared_mode && pulldown_fitted
      |=> irq_pulldown == $past(irq_onehot))
    else $error("pull-down missing on shared line");
  a_normal_no_pd: assert property (@(posedge clk) disable iff (srst)
      !shared_mode |=> irq_pulldown == 4'h0)
    else $error("pull-down applied in normal mode");
  a_reset_dflt: assert property (@(posedge clk)
      srst |=> st_ff.sw == 7'h47 && st_ff.irqsel == 4'h8)
    else $error("reset default not base 238 and line 5");

endmodule : scdec_decode

// >>> logic/scdec_pkg.sv
/*
  Constants shared by the serial adapter I/O decoder: address layout,
  port offsets, factory strap defaults and the routing encodings.
  Assumes a 10-bit host I/O address and 8-bit host data.
*/
package scdec_pkg;

  // Host address layout
  localparam int unsigned ADDR_W     = 10;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned SW_W       = 7;
  localparam int unsigned OFS_W      = 3;
  localparam int unsigned BLOCK_SIZE = 8;

  // Legal base range, aligned to eight locations
  localparam logic [9:0] BASE_MIN = 10'h100;
  localparam logic [9:0] BASE_MAX = 10'h3F8;

  // Offsets within the decoded block
  localparam logic [2:0] OFS_CHAN_A_DATA = 3'h0;
  localparam logic [2:0] OFS_CHAN_A_CTRL = 3'h1;
  localparam logic [2:0] OFS_CHAN_B_DATA = 3'h2;
  localparam logic [2:0] OFS_CHAN_B_CTRL = 3'h3;
  localparam logic [2:0] OFS_BOARD_CS    = 3'h4;

  // Factory settings: base 238 hex gives switches open/closed as 1000111
  localparam logic [9:0] DEFAULT_BASE    = 10'h238;
  localparam logic [6:0] DEFAULT_SWITCH  = 7'h47;
  localparam logic [3:0] DEFAULT_IRQ_SEL = 4'h8;

  // Interrupt line select bits, one hot, none means no interrupt
  localparam int unsigned IRQ_N   = 4;
  localparam int unsigned IRQ_2_9 = 0;
  localparam int unsigned IRQ_3   = 1;
  localparam int unsigned IRQ_4   = 2;
  localparam int unsigned IRQ_5   = 3;

  // Value returned on undecoded reads
  localparam logic [7:0] UNDEF_READ = 8'hFF;

  // Strobe one-hot selects
  typedef enum logic [4:0] {
    SCDEC_SEL_NONE = 5'h00,
    SCDEC_SEL_AD   = 5'h01,
    SCDEC_SEL_AC   = 5'h02,
    SCDEC_SEL_BD   = 5'h04,
    SCDEC_SEL_BC   = 5'h08,
    SCDEC_SEL_CS   = 5'h10
  } scdec_sel_t;

endpackage : scdec_pkg

// >>> tb/scdec_far_model.sv
/*
  Far side model: serial controller and board port read data.
  Assumes the decoder samples read data in the host request cycle.
*/
`timescale 1ns/1ps
module scdec_far_model (
  input  wire logic       clk,
  output logic      [7:0] serial_rdata,
  output logic      [7:0] board_rdata
);
  logic [7:0] cnt_ff = 8'h5A;

  // Data moves every cycle so a stale or misrouted sample shows up
  always_ff @(posedge clk) begin
    cnt_ff <= cnt_ff + 8'h3B;
  end

  // Two ports never agree, catching a swapped read mux
  assign serial_rdata = cnt_ff;
  assign board_rdata  = ~cnt_ff ^ 8'h0F;
endmodule : scdec_far_model

// >>> tb/serial_card_io_decode_bench.sv
/*
  Self-checking bench for the serial adapter I/O decoder.
  Assumes scdec_pkg and the far side model are compiled first.
*/
`timescale 1ns/1ps
module serial_card_io_decode_bench;
  import scdec_pkg::*;
  logic       clk, srst, rd, wr, aen, shm, pdf, dirq, hit;
  logic [9:0] addr;
  logic [7:0] wd, rdat, pwd, sd, bd;
  logic [6:0] sw;
  logic [4:0] prd, pwr;
  logic [3:0] hdr, io, ioe, ipd;
  int         fails = 0, compares = 0, i, j;
  logic [7:0] exp_q[$];

  scdec_decode uut (.clk(clk), .srst(srst), .host_addr(addr),
    .host_wdata(wd), .host_rd(rd), .host_wr(wr), .host_aen(aen),
    .host_rdata(rdat), .host_hit(hit), .base_address_switch(sw),
    .interrupt_select_header(hdr), .shared_mode(shm),
    .pulldown_fitted(pdf), .port_rd(prd), .port_wr(pwr),
    .port_wdata(pwd), .serial_rdata(sd), .board_rdata(bd),
    .dual_serial_controller_irq(dirq), .irq_out(io),
    .irq_oe_n(ioe), .irq_pulldown(ipd));
  scdec_far_model far (.clk(clk), .serial_rdata(sd), .board_rdata(bd));

  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One host cycle; expectation built before the edge from the rules
  task automatic acc(logic [9:0] a, logic r, logic e);
    logic       blk;
    logic [4:0] sel;
    logic [7:0] x;
    addr = a;
    rd = r;
    wr = !r;
    aen = e;
    wd = 8'($urandom);
    blk = e && a[9:3] == sw && sw >= 7'h20;
    sel = (blk && a[2:0] < 5) ? 5'h01 << a[2:0] : 5'h00;
    x = !blk ? 8'hFF : a[2:0] < 4 ? sd : a[2:0] == 4 ? bd : 8'hFF;
    // Writes leave the read bus at its idle value
    exp_q.push_back(r ? x : 8'hFF);
    @(posedge clk);
    #5;
    chk("hit", {7'h0, hit}, {7'h0, blk});
    chk("port_rd", {3'h0, prd}, r ? {3'h0, sel} : 8'h00);
    chk("port_wr", {3'h0, pwr}, r ? 8'h00 : {3'h0, sel});
    chk("rdata", rdat, exp_q.pop_front());
    if (!r && blk) chk("wdata", pwd, wd);
  endtask : acc

  // Interrupt steering; the header is registered first, so two cycles
  task automatic irqc(logic [3:0] h, logic s, logic p, logic q);
    logic [3:0] oh, eo;
    hdr = h;
    shm = s;
    pdf = p;
    dirq = q;
    oh = ($countones(h) == 1) ? h : 4'h0;
    eo = s ? ~(oh & {4{q}}) : ~oh;
    repeat (2) @(posedge clk);
    #5;
    chk("irq_oe_n", {4'h0, ioe}, {4'h0, eo});
    chk("irq_out", {4'h0, io & ~eo}, {4'h0, oh & {4{q}} & ~eo});
    chk("irq_pulldown", {4'h0, ipd}, {4'h0, s ? (oh & {4{p}}) : 4'h0});
  endtask : irqc

  task automatic end_of_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #(3000 * 50);
    fails++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'he366_e287));
    {srst, rd, wr, aen, shm, pdf, dirq} = 7'h40;
    addr = 10'h000;
    wd = 8'h00;
    sw = DEFAULT_SWITCH;
    hdr = DEFAULT_IRQ_SEL;
    repeat (2) @(posedge clk);
    #5;
    chk("reset oe_n", {4'h0, ioe}, 8'h0F);
    srst = 0;
    // Every offset at the factory base, reads then writes back to back
    for (i = 0; i < 16; i++) acc(DEFAULT_BASE + 10'(i % 8), i < 8, 1);
    $display("test offsets done");
    // Random switch settings, including bases below the legal range
    for (i = 0; i < 40; i++) begin
      rd = 0;
      wr = 0;
      sw = 7'($urandom);
      @(posedge clk);
      #5;
      for (j = 0; j < 5; j++)
        acc(j % 2 ? {sw, 3'($urandom)} : 10'($urandom), 1'($urandom),
            ($urandom % 8) != 0);
    end
    rd = 0;
    wr = 0;
    $display("test decode done");
    for (i = 0; i < 64; i++) irqc(4'(i), i[4], i[5], 1'($urandom));
    $display("test irq done");
    end_of_test();
  end
endmodule : serial_card_io_decode_bench
